// *** src/csr_pkg.sv ***
// Constants, types and helpers shared by the chip-settings readback block.
package csr_pkg;

    // ***********************************************************************
    // Command and reply codes
    // ***********************************************************************
    localparam logic [7:0] CSR_CMD_READ = 8'hB0;
    localparam logic [7:0] CSR_SUB_CHIP = 8'h00;
    localparam logic [7:0] CSR_RC_OK = 8'h00;
    localparam logic [7:0] CSR_RC_UNSUP = 8'h01;
    localparam logic [7:0] CSR_STRUCT_LEN = 8'h0E;
    localparam logic [7:0] CSR_FILL = 8'h00;
    localparam logic [5:0] CSR_IDX_CODE = 6'h00;
    localparam logic [5:0] CSR_IDX_RC = 6'h01;
    localparam logic [5:0] CSR_IDX_LEN = 6'h02;
    localparam logic [5:0] CSR_IDX_B4 = 6'h04;
    localparam logic [5:0] CSR_IDX_B5 = 6'h05;
    localparam logic [5:0] CSR_IDX_B6 = 6'h06;
    localparam logic [5:0] CSR_IDX_LAST = 6'h3F;

    // ***********************************************************************
    // Register map and field layout
    // ***********************************************************************
    localparam logic [7:0] CSR_OFS_SETTINGS = 8'h00_00;
    localparam logic [7:0] CSR_OFS_CONTROL = 8'h00_04;
    localparam logic [7:0] CSR_OFS_STATUS = 8'h00_08;
    localparam logic [7:0] CSR_OFS_DAC = 8'h00_0C;
    localparam logic [23:0] CSR_SETTINGS_RST = 24'h00_0000;
    localparam logic [3:0] CSR_CONTROL_RST = 4'h0;
    localparam int CSR_CTL_BUS_EN = 0;
    localparam int CSR_CTL_SUSP_EN = 1;
    localparam int CSR_CTL_CFG_EN = 2;
    localparam int CSR_CTL_CLK_EN = 3;
    localparam int CSR_B4_SERIAL = 7;
    localparam int CSR_B4_RX = 6;
    localparam int CSR_B4_TX = 5;
    localparam int CSR_B4_BUS = 4;
    localparam int CSR_B4_SUSP = 3;
    localparam int CSR_B4_CFG = 2;
    localparam int CSR_B6_REF_SRC = 5;

    // ***********************************************************************
    // Types
    // ***********************************************************************
    typedef enum logic [1:0] {
        CSR_SEC_OPEN = 2'h0,
        CSR_SEC_PASSWORD = 2'h1,
        CSR_SEC_LOCKED = 2'h2
    } csr_sec_t;

    typedef struct packed {
        logic [7:0] b4;
        logic [7:0] b5;
        logic [7:0] b6;
    } csr_settings_t;

    typedef struct packed {
        logic rx_busy;
        logic tx_busy;
        logic bus_busy;
        logic suspended;
        logic configured;
    } csr_act_t;

    typedef struct packed {
        logic rx_activity_indicator;
        logic tx_activity_indicator;
        logic bus_activity_indicator;
        logic suspend_indicator;
        logic configured_indicator;
    } csr_ind_t;

    typedef struct packed {
        logic [1:0] level;
        logic internal_sel;
        logic [4:0] value;
    } csr_dac_t;

    // Indicator level: idle level, inverted while the activity is present.
    function automatic logic csr_level(input logic idle_lvl, input logic active);
        csr_level = idle_lvl ^ active;
    endfunction : csr_level

endpackage : csr_pkg

// *** src/csr_ind_bank.sv ***
// Indicator pin drivers for the five activity and status indicators.
module csr_ind_bank
    import csr_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [7:0] b4_i,
    input wire logic [3:0] ctl_i,
    input wire csr_act_t act_i,
    output csr_ind_t ind_o
);

    // A disabled indicator parks at its idle level so it never shows false activity.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ind_o <= '0;
        end else begin
            ind_o.rx_activity_indicator <= csr_level(b4_i[CSR_B4_RX], act_i.rx_busy);
            ind_o.tx_activity_indicator <= csr_level(b4_i[CSR_B4_TX], act_i.tx_busy);
            ind_o.bus_activity_indicator <= csr_level(b4_i[CSR_B4_BUS],
                act_i.bus_busy & ctl_i[CSR_CTL_BUS_EN]);
            ind_o.suspend_indicator <= csr_level(b4_i[CSR_B4_SUSP],
                act_i.suspended & ctl_i[CSR_CTL_SUSP_EN]);
            ind_o.configured_indicator <= csr_level(b4_i[CSR_B4_CFG],
                act_i.configured & ctl_i[CSR_CTL_CFG_EN]);
        end
    end

endmodule : csr_ind_bank

// *** src/csr_clkdiv.sv ***
// Clock-output divider for the general pin.
module csr_clkdiv
    import csr_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic en_i,
    input wire logic [4:0] div_i,
    output logic clk_o
);

    logic [4:0] count;

    // The output toggles every div_i cycles; a divider of zero holds the pin low.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            count <= '0;
            clk_o <= 1'b0;
        end else if (!en_i || div_i == '0) begin
            count <= '0;
            clk_o <= 1'b0;
        end else if (count >= div_i - 5'd1) begin
            count <= '0;
            clk_o <= ~clk_o;
        end else begin
            count <= count + 5'd1;
        end
    end

endmodule : csr_clkdiv

// *** src/csr_top.sv ***
// Chip-settings block: register slave, settings reply and settings outputs.
//
// Added by the designer: the register addresses and register access over APB.
module csr_top
    import csr_pkg::*;
(
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic [7:0] PADDR_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic REQ_VALID_I,
    input wire logic [7:0] REQ_CMD_I,
    input wire logic [7:0] REQ_SUB_I,
    output logic REQ_READY_O,
    output logic RPL_VALID_O,
    output logic [7:0] RPL_DATA_O,
    output logic RPL_LAST_O,
    input wire logic RPL_READY_I,
    input wire csr_act_t ACT_I,
    output csr_ind_t IND_O,
    output logic SERIAL_EN_O,
    output csr_sec_t SEC_LEVEL_O,
    output logic CLKOUT_O,
    output csr_dac_t DAC_O
);

    // ***********************************************************************
    // Register bus
    // ***********************************************************************
    csr_settings_t settings;
    logic [3:0] control;
    logic [4:0] dac_live;
    logic dac_loaded;
    logic access;
    logic hit;
    logic [31:0] next_rdata;

    typedef enum {CSR_IDLE, CSR_SEND} csr_state_t;
    csr_state_t state;

    // The slave answers one cycle into the access phase; PREADY drops afterwards.
    assign access = PSEL_I && PENABLE_I && !PREADY_O;

    always_comb begin
        hit = 1'b1;
        next_rdata = '0;
        case (PADDR_I)
            CSR_OFS_SETTINGS: next_rdata = {8'h00, settings};
            CSR_OFS_CONTROL: next_rdata = {28'h000_0000, control};
            CSR_OFS_STATUS: next_rdata = {26'h000_0000, state == CSR_SEND, ACT_I};
            CSR_OFS_DAC: next_rdata = {27'h000_0000, dac_live};
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= '0;
        end else begin
            PREADY_O <= access;
            PSLVERR_O <= access && !hit;
            PRDATA_O <= (access && !PWRITE_I && hit) ? next_rdata : '0;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            settings <= CSR_SETTINGS_RST;
            control <= CSR_CONTROL_RST;
        end else if (access && PWRITE_I) begin
            if (PADDR_I == CSR_OFS_SETTINGS) begin
                settings <= PWDATA_I[23:0];
            end
            if (PADDR_I == CSR_OFS_CONTROL) begin
                control <= PWDATA_I[3:0];
            end
        end
    end

    // ***********************************************************************
    // DAC value
    // ***********************************************************************
    // Reset clears the load flag and the live value; the stored field is copied on the
    // first edge after release so no port value enters the reset branch.
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            dac_loaded <= 1'b0;
            dac_live <= '0;
        end else if (!dac_loaded) begin
            dac_loaded <= 1'b1;
            dac_live <= settings.b6[4:0];
        end else if (access && PWRITE_I && PADDR_I == CSR_OFS_DAC) begin
            dac_live <= PWDATA_I[4:0];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            DAC_O <= '0;
        end else begin
            DAC_O.level <= settings.b6[7:6];
            DAC_O.internal_sel <= settings.b6[CSR_B6_REF_SRC];
            DAC_O.value <= dac_live;
        end
    end

    // ***********************************************************************
    // Enumeration and security outputs
    // ***********************************************************************
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            SERIAL_EN_O <= 1'b0;
            SEC_LEVEL_O <= CSR_SEC_OPEN;
        end else begin
            SERIAL_EN_O <= settings.b4[CSR_B4_SERIAL];
            case (settings.b4[1:0])
                2'h3, 2'h2: SEC_LEVEL_O <= CSR_SEC_LOCKED;
                2'h1: SEC_LEVEL_O <= CSR_SEC_PASSWORD;
                default: SEC_LEVEL_O <= CSR_SEC_OPEN;
            endcase
        end
    end

    // ***********************************************************************
    // Settings reply
    // ***********************************************************************
    csr_settings_t snap;
    logic sub_ok;
    logic [5:0] idx;
    logic take;
    logic advance;

    // Settings are frozen at the request so a bus write during the reply
    // cannot tear the structure the host receives.
    function automatic logic [7:0] reply_byte(input logic [5:0] i, input logic ok,
                                              input csr_settings_t s);
        logic [7:0] b;
        b = CSR_FILL;
        case (i)
            CSR_IDX_CODE: b = CSR_CMD_READ;
            CSR_IDX_RC: b = ok ? CSR_RC_OK : CSR_RC_UNSUP;
            CSR_IDX_LEN: b = ok ? CSR_STRUCT_LEN : CSR_FILL;
            CSR_IDX_B4: b = ok ? s.b4 : CSR_FILL;
            CSR_IDX_B5: b = ok ? s.b5 : CSR_FILL;
            CSR_IDX_B6: b = ok ? s.b6 : CSR_FILL;
            default: b = CSR_FILL;
        endcase
        reply_byte = b;
    endfunction : reply_byte

    // Requests with another command code are consumed and dropped.
    assign take = (state == CSR_IDLE) && REQ_VALID_I && REQ_READY_O;
    assign advance = (state == CSR_SEND) && RPL_VALID_O && RPL_READY_I;

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            state <= CSR_IDLE;
            REQ_READY_O <= 1'b0;
            snap <= '0;
            sub_ok <= 1'b0;
            idx <= '0;
        end else begin
            case (state)
                CSR_IDLE: begin
                    REQ_READY_O <= 1'b1;
                    if (take && REQ_CMD_I == CSR_CMD_READ) begin
                        state <= CSR_SEND;
                        REQ_READY_O <= 1'b0;
                        snap <= settings;
                        sub_ok <= (REQ_SUB_I == CSR_SUB_CHIP);
                        idx <= CSR_IDX_CODE;
                    end
                end
                CSR_SEND: begin
                    if (advance) begin
                        if (idx == CSR_IDX_LAST) begin
                            state <= CSR_IDLE;
                            REQ_READY_O <= 1'b1;
                        end else begin
                            idx <= idx + 6'd1;
                        end
                    end
                end
                default: state <= CSR_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            RPL_VALID_O <= 1'b0;
            RPL_DATA_O <= '0;
            RPL_LAST_O <= 1'b0;
        end else if (take && REQ_CMD_I == CSR_CMD_READ) begin
            RPL_VALID_O <= 1'b1;
            RPL_DATA_O <= CSR_CMD_READ;
            RPL_LAST_O <= 1'b0;
        end else if (advance) begin
            if (idx == CSR_IDX_LAST) begin
                RPL_VALID_O <= 1'b0;
                RPL_DATA_O <= '0;
                RPL_LAST_O <= 1'b0;
            end else begin
                RPL_DATA_O <= reply_byte(idx + 6'd1, sub_ok, snap);
                RPL_LAST_O <= (idx + 6'd1 == CSR_IDX_LAST);
            end
        end
    end

    // ***********************************************************************
    // Indicators and clock output
    // ***********************************************************************
    csr_ind_bank u_ind (
        .clk_i(CLK_I),
        .srst_i(SRST_I),
        .b4_i(settings.b4),
        .ctl_i(control),
        .act_i(ACT_I),
        .ind_o(IND_O)
    );

    csr_clkdiv u_clkdiv (
        .clk_i(CLK_I),
        .srst_i(SRST_I),
        .en_i(control[CSR_CTL_CLK_EN]),
        .div_i(settings.b5[4:0]),
        .clk_o(CLKOUT_O)
    );

endmodule : csr_top

// *** tb/csr_chk.sv ***
// Port-level assertions for the chip-settings block.
module csr_chk
    import csr_pkg::*;
(
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic [7:0] PADDR_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic REQ_VALID_I,
    input wire logic [7:0] REQ_CMD_I,
    input wire logic REQ_READY_O,
    input wire logic RPL_VALID_O,
    input wire logic [7:0] RPL_DATA_O,
    input wire logic RPL_LAST_O,
    input wire logic RPL_READY_I,
    input wire csr_act_t ACT_I,
    input wire csr_ind_t IND_O,
    input wire logic SERIAL_EN_O,
    input wire csr_sec_t SEC_LEVEL_O,
    input wire logic CLKOUT_O,
    input wire csr_dac_t DAC_O
);
    // ****************
    // Settings shadow
    // ****************
    // Outputs may trail a write by a cycle, so checks pause around writes.
    logic wr, wr_d, rst_d, ok;
    logic [23:0] sh;
    logic [3:0] ctl;
    assign wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
    assign ok = !wr && !wr_d && !rst_d;
    always_ff @(posedge CLK_I) begin
        wr_d <= wr;
        rst_d <= SRST_I;
    end
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            sh <= '0;
            ctl <= '0;
        end else if (wr && PADDR_I == CSR_OFS_SETTINGS) begin
            sh <= PWDATA_I[23:0];
        end else if (wr && PADDR_I == CSR_OFS_CONTROL) begin
            ctl <= PWDATA_I[3:0];
        end
    end
    default clocking @(posedge CLK_I);
    endclocking
    default disable iff (SRST_I);
    a_serial_follow: assert property (ok |-> SERIAL_EN_O == sh[23])
        else $error("serial enable differs from setting");
    a_rx_level: assert property (ok |-> IND_O.rx_activity_indicator ==
        (sh[22] ^ $past(ACT_I.rx_busy))) else $error("receive indicator wrong");
    a_tx_level: assert property (ok |-> IND_O.tx_activity_indicator ==
        (sh[21] ^ $past(ACT_I.tx_busy))) else $error("transmit indicator wrong");
    a_bus_level: assert property (ok |-> IND_O.bus_activity_indicator ==
        (sh[20] ^ ($past(ACT_I.bus_busy) && ctl[0]))) else $error("bus indicator wrong");
    a_susp_level: assert property (ok |-> IND_O.suspend_indicator ==
        (sh[19] ^ ($past(ACT_I.suspended) && ctl[1]))) else $error("suspend indicator wrong");
    a_cfg_level: assert property (ok |-> IND_O.configured_indicator ==
        (sh[18] ^ ($past(ACT_I.configured) && ctl[2]))) else $error("configured indicator wrong");
    a_sec_code: assert property (ok |-> SEC_LEVEL_O ==
        (sh[17] ? CSR_SEC_LOCKED : csr_sec_t'(sh[17:16]))) else $error("security level wrong");
    a_dac_ref: assert property (ok |-> {DAC_O.level, DAC_O.internal_sel} == sh[7:5])
        else $error("reference selection wrong");
    a_reply_head: assert property (REQ_VALID_I && REQ_READY_O && REQ_CMD_I == CSR_CMD_READ |=>
        RPL_VALID_O && RPL_DATA_O == CSR_CMD_READ && !REQ_READY_O) else $error("reply head wrong");
    c_reply_end: cover property (RPL_VALID_O && RPL_READY_I && RPL_LAST_O);
    c_apb_err: cover property (PREADY_O && PSLVERR_O);
    c_clk_out: cover property ($rose(CLKOUT_O));
endmodule : csr_chk

bind csr_top csr_chk csr_chk_i (.*);

// *** tb/csr_host_model.sv ***
// Host-side model that requests the settings reply and takes its bytes.
module csr_host_model
    import csr_pkg::*;
(
    input wire logic clk_i,
    input wire logic req_ready_i,
    input wire logic rpl_valid_i,
    input wire logic [7:0] rpl_data_i,
    input wire logic rpl_last_i,
    output logic req_valid_o,
    output logic [7:0] req_cmd_o,
    output logic [7:0] req_sub_o,
    output logic rpl_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rx [64];
    int cnt = 0;
    bit slow = 1'b0;
    bit done = 1'b0;
    initial begin
        req_valid_o = 1'b0;
        req_cmd_o = 8'h00;
        req_sub_o = 8'h00;
        rpl_ready_o = 1'b1;
    end
    // A slow host accepts only every other cycle, to stretch each byte.
    always @(posedge clk_i) begin
        if (rpl_valid_i === 1'b1 && rpl_ready_o === 1'b1) begin
            rx[cnt[5:0]] = rpl_data_i;
            cnt = cnt + 1;
            done = (rpl_last_i === 1'b1);
        end
        rpl_ready_o <= slow ? ~rpl_ready_o : 1'b1;
    end
    task automatic request(input logic [7:0] cmd, input logic [7:0] sub, input bit s);
        slow = s;
        cnt = 0;
        done = 1'b0;
        @(posedge clk_i);
        req_valid_o <= 1'b1;
        req_cmd_o <= cmd;
        req_sub_o <= sub;
        do @(posedge clk_i); while (req_ready_i !== 1'b1);
        req_valid_o <= 1'b0;
        req_cmd_o <= ~cmd;
        req_sub_o <= ~sub;
    endtask : request
endmodule : csr_host_model

// *** tb/csr_top_tb.sv ***
// Self-checking bench for the chip-settings block.
module csr_top_tb
    import csr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, req_cmd, req_sub, rpl_data;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, req_valid, req_ready, rpl_valid, rpl_last, rpl_ready, serial_en, clkout;
    csr_act_t act = '0;
    csr_ind_t ind;
    csr_sec_t sec;
    csr_dac_t dac;
    int mismatches = 0, checks = 0, cycles = 0;
    always #2.5 clk = ~clk;
    csr_top csr_top_i (.CLK_I(clk), .SRST_I(srst), .PADDR_I(paddr), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .REQ_VALID_I(req_valid), .REQ_CMD_I(req_cmd),
        .REQ_SUB_I(req_sub), .REQ_READY_O(req_ready), .RPL_VALID_O(rpl_valid),
        .RPL_DATA_O(rpl_data), .RPL_LAST_O(rpl_last), .RPL_READY_I(rpl_ready), .ACT_I(act),
        .IND_O(ind), .SERIAL_EN_O(serial_en), .SEC_LEVEL_O(sec), .CLKOUT_O(clkout), .DAC_O(dac));
    csr_host_model csr_host_model_i (.clk_i(clk), .req_ready_i(req_ready),
        .rpl_valid_i(rpl_valid), .rpl_data_i(rpl_data), .rpl_last_i(rpl_last),
        .req_valid_o(req_valid), .req_cmd_o(req_cmd), .req_sub_o(req_sub), .rpl_ready_o(rpl_ready));
    // ****************
    // Report, check and access tasks
    // ****************
    task automatic final_report();
        if (mismatches == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One idle cycle follows each transfer, so psel never changes twice in a step.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp,
        input logic err);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        if (!w) check(prdata, exp);
        check(32'(pslverr), 32'(err));
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end
    initial begin
        logic [4:0] idle;
        logic [55:0] hd;
        logic lvl;
        int t;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        check(32'(dac), 32'h0);
        apb(0, CSR_OFS_SETTINGS, 0, 32'h0, 0);
        apb(0, 8'h10, 0, 32'h0, 1);
        for (int i = 0; i < 4; i++) begin
            apb(1, CSR_OFS_SETTINGS, {8'h00, i[0], 5'h00, i[1:0], 8'hFF, i[1:0], i[0], 5'h15}, 0, 0);
            check(32'(serial_en), 32'(i[0]));
            check(32'(sec), i > 1 ? 32'(CSR_SEC_LOCKED) : 32'(i));
            check(32'(dac), 32'({i[1:0], i[0], 5'h00}));
        end
        apb(1, CSR_OFS_DAC, 32'h0000_000A, 0, 0);
        apb(0, CSR_OFS_DAC, 0, 32'h0000_000A, 0);
        // A second reset must drop the written value and reload the stored field.
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        check(32'(dac), 32'h0);
        check(32'(serial_en), 32'h0);
        for (int k = 0; k < 8; k++) begin
            idle = 5'(k * 13);
            apb(1, CSR_OFS_SETTINGS, {8'h00, 1'b0, idle, 18'h0_0000}, 0, 0);
            apb(1, CSR_OFS_CONTROL, {29'h0, k[2:0]}, 0, 0);
            act <= csr_act_t'(5'(~(k * 5)));
            repeat (2) @(posedge clk);
            check(32'(ind), 32'(idle ^ (act & {2'b11, k[0], k[1], k[2]})));
        end
        apb(0, CSR_OFS_STATUS, 0, 32'(act), 0);
        apb(1, CSR_OFS_SETTINGS, 32'h00A5_3C96, 0, 0);
        for (int m = 0; m < 3; m++) begin
            csr_host_model_i.request(m == 2 ? 8'h51 : CSR_CMD_READ, 8'(m), m[0]);
            t = 0;
            while (!csr_host_model_i.done && t < 300) begin
                @(posedge clk);
                t++;
            end
            hd = {CSR_CMD_READ, m ? CSR_RC_UNSUP : CSR_RC_OK, m ? 16'h0000 : 16'h0E00, 24'hA5_3C96};
            if (m) hd[23:0] = 24'h0;
            check(32'(csr_host_model_i.cnt), m == 2 ? 0 : 64);
            check(32'(csr_host_model_i.done), 32'(m < 2));
            for (int b = 0; b < 64 && m < 2; b++) begin
                check(32'(csr_host_model_i.rx[b]), b < 7 ? 32'(hd[55 - 8 * b -: 8]) : 0);
            end
        end
        // Any 30-cycle window of a clock that toggles every d cycles holds 30/d toggles.
        for (int d = 3; d < 6; d += 2) begin
            apb(1, CSR_OFS_SETTINGS, {16'h0000, 3'b111, 5'(d), 8'h00}, 0, 0);
            apb(1, CSR_OFS_CONTROL, 32'h0000_0008, 0, 0);
            repeat (12) @(posedge clk);
            lvl = clkout;
            t = 0;
            repeat (30) begin
                @(posedge clk);
                t += int'(clkout !== lvl);
                lvl = clkout;
            end
            check(32'(t), 32'(30 / d));
        end
        final_report();
    end
endmodule : csr_top_tb
